//--- hw/bltd_map.vh
/*
 * Constants for the burst/latency/recovery mode register decode: field
 * positions, select codes, length and reserved recovery codes and timing offsets.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef BLTD_MAP_VH
`define BLTD_MAP_VH

`define BLTD_SEL_THIS      3'h0
`define BLTD_SEL_IGNORE    3'h7
`define BLTD_BL_LO         0
`define BLTD_BL_HI         1
`define BLTD_BT_BIT        3
`define BLTD_TM_BIT        7
`define BLTD_WR_LO         9
`define BLTD_WR_HI         11
`define BLTD_CHOP_BIT      12
`define BLTD_BL_FIXED8     2'h0
`define BLTD_BL_PERCMD     2'h1
`define BLTD_BL_FIXED4     2'h2
`define BLTD_BL_RSVD       2'h3
`define BLTD_WR_RSVD       3'h7
`define BLTD_CHOP_PULLIN   6'h02
`define BLTD_REG_W         18

`endif

//--- hw/bltd_mode_zero.v
/*
 * Mode register zero decode: captures mode-register-set commands aimed at
 * this register and turns the fields into burst, order, latency and
 * recovery controls for the read/write datapath.
 * Assumes command/address inputs synchronous to i_clk, commands one cycle
 * strobes, and that the controller keeps its own timing and field rules.
 */
`timescale 1ns/1ns
`default_nettype none
`include "bltd_map.vh"

module bltd_mode_zero #(
	parameter LAT_W = 6
) (
	// Clock and reset
	input  wire                    i_clk,
	input  wire                    i_rst_n,
	// Mode register set command
	input  wire                    i_mrs,
	input  wire                    i_bank_group_bit_zero,
	input  wire                    i_bank_addr_bit_one,
	input  wire                    i_bank_addr_bit_zero,
	input  wire [`BLTD_REG_W-1:0]  i_addr,
	// Latencies held in other mode registers
	input  wire [LAT_W-1:0]        i_column_read_latency,
	input  wire [LAT_W-1:0]        i_added_command_latency,
	input  wire [LAT_W-1:0]        i_precharge_period,
	// Read/write command
	input  wire                    i_rd,
	input  wire                    i_wr,
	input  wire [2:0]              i_start_col,
	// Beat slot strobe for the current burst, index 0..7
	input  wire                    i_beat_valid,
	input  wire [2:0]              i_beat_idx,
	// Decoded configuration
	output reg  [`BLTD_REG_W-1:0]  o_config,
	output reg                     o_interleaved,
	output reg  [1:0]              o_burst_mode,
	output reg                     o_test_mode,
	output reg  [LAT_W-1:0]        o_write_recovery,
	output reg  [LAT_W-1:0]        o_read_to_precharge_setting,
	output reg  [LAT_W-1:0]        o_autoprecharge_write_to_activate,
	output reg  [LAT_W-1:0]        o_total_read_latency,
	// Per-access results
	output reg                     o_burst_chop_four,
	output reg                     o_is_write,
	output reg  [LAT_W-1:0]        o_write_pullin,
	output reg  [2:0]              o_beat_col,
	output wire                    o_dq_oe_n
);

	reg  [`BLTD_REG_W-1:0] cfg_q;
	reg                    chop_q;
	reg                    wr_q;
	reg  [2:0]             start_q;
	reg  [2:0]             mr_sel;
	reg  [2:0]             wr_code;
	reg  [LAT_W-1:0]       wr_cyc;
	reg  [LAT_W-1:0]       rtp_cyc;
	reg                    chop_d;
	reg  [2:0]             col_d;
	reg  [LAT_W:0]         dal_sum;
	reg  [LAT_W:0]         rl_sum;
	reg  [LAT_W-1:0]       pull_d;

	// Only selection code 000 lands here; 111 gets no response at all
	always @* begin
		mr_sel = {i_bank_group_bit_zero, i_bank_addr_bit_one, i_bank_addr_bit_zero};
	end

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cfg_q <= {`BLTD_REG_W{1'b0}};
		end else if (i_mrs && mr_sel == `BLTD_SEL_THIS) begin
			// Every field is overwritten; the controller must resend all of them
			// Test mode bit is stored as written, its effect is left undefined
			cfg_q <= i_addr;
		end
	end

	// Recovery / read-to-precharge table; reserved code holds the largest pair
	always @* begin
		wr_code = cfg_q[`BLTD_WR_HI:`BLTD_WR_LO];
		case (wr_code)
		3'h0: begin
			wr_cyc  = 6'd10;
			rtp_cyc = 6'd5;
		end
		3'h1: begin
			wr_cyc  = 6'd12;
			rtp_cyc = 6'd6;
		end
		3'h2: begin
			wr_cyc  = 6'd14;
			rtp_cyc = 6'd7;
		end
		3'h3: begin
			wr_cyc  = 6'd16;
			rtp_cyc = 6'd8;
		end
		3'h4: begin
			wr_cyc  = 6'd18;
			rtp_cyc = 6'd9;
		end
		3'h5: begin
			wr_cyc  = 6'd20;
			rtp_cyc = 6'd10;
		end
		default: begin
			wr_cyc  = 6'd24;
			rtp_cyc = 6'd12;
		end
		endcase
	end

	// Sums carry one spare bit; the top bit is dropped on purpose since
	// legal latency settings never overflow the latency width
	always @* begin
		dal_sum = {1'b0, wr_cyc} + {1'b0, i_precharge_period};
		rl_sum  = {1'b0, i_added_command_latency} + {1'b0, i_column_read_latency};
	end

	// Fixed chop pulls recovery and turnaround start in; per-command chop does not
	always @* begin
		if (cfg_q[`BLTD_BL_HI:`BLTD_BL_LO] == `BLTD_BL_FIXED4) begin
			pull_d = `BLTD_CHOP_PULLIN;
		end else begin
			pull_d = {LAT_W{1'b0}};
		end
	end

	// Per-command chop decision taken with the command
	// Reserved length code 11 falls to fixed eight, the safer full burst
	always @* begin
		case (cfg_q[`BLTD_BL_HI:`BLTD_BL_LO])
		`BLTD_BL_FIXED4: chop_d = 1'b1;
		`BLTD_BL_PERCMD: chop_d = i_addr[`BLTD_CHOP_BIT];
		default:         chop_d = 1'b0;
		endcase
	end

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			chop_q  <= 1'b0;
			wr_q    <= 1'b0;
			start_q <= 3'h0;
		end else if (i_rd || i_wr) begin
			chop_q  <= chop_d;
			wr_q    <= i_wr;
			start_q <= i_start_col;
		end
	end

	// Beat column order for the latched access
	always @* begin
		if (wr_q) begin
			// Low bits ignored; chop write takes the half chosen by bit 2
			col_d = chop_q ? {start_q[2], i_beat_idx[1:0]} : i_beat_idx;
		end else if (cfg_q[`BLTD_BT_BIT]) begin
			col_d = i_beat_idx ^ start_q;
		end else begin
			// Sequential wraps modulo four inside each half, then flips halves
			col_d = {start_q[2] ^ i_beat_idx[2], start_q[1:0] + i_beat_idx[1:0]};
		end
	end

	// Chop reads release data and strobe for the last four slots
	// Kept combinational so the release lines up with the slot itself
	assign o_dq_oe_n = ~(i_beat_valid && !wr_q && !(chop_q && i_beat_idx[2]));

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_config                          <= {`BLTD_REG_W{1'b0}};
			o_interleaved                     <= 1'b0;
			o_burst_mode                      <= 2'h0;
			o_test_mode                       <= 1'b0;
			o_write_recovery                  <= {LAT_W{1'b0}};
			o_read_to_precharge_setting       <= {LAT_W{1'b0}};
			o_autoprecharge_write_to_activate <= {LAT_W{1'b0}};
			o_total_read_latency              <= {LAT_W{1'b0}};
			o_burst_chop_four                 <= 1'b0;
			o_is_write                        <= 1'b0;
			o_write_pullin                    <= {LAT_W{1'b0}};
			o_beat_col                        <= 3'h0;
		end else begin
			o_config                          <= cfg_q;
			o_interleaved                     <= cfg_q[`BLTD_BT_BIT];
			o_burst_mode                      <= cfg_q[`BLTD_BL_HI:`BLTD_BL_LO];
			o_test_mode                       <= cfg_q[`BLTD_TM_BIT];
			o_write_recovery                  <= wr_cyc;
			o_read_to_precharge_setting       <= rtp_cyc;
			o_autoprecharge_write_to_activate <= dal_sum[LAT_W-1:0];
			// Whole-clock latency only, no half-cycle option
			o_total_read_latency              <= rl_sum[LAT_W-1:0];
			o_burst_chop_four                 <= chop_q;
			o_is_write                        <= wr_q;
			o_write_pullin                    <= pull_d;
			o_beat_col                        <= col_d;
		end
	end

endmodule // bltd_mode_zero
`default_nettype wire

//--- sim/bltd_mode_zero_assertions.sv
/* Checker for the mode register zero decode.
 * Assumes it is bound onto bltd_mode_zero and shares its LAT_W. */
`timescale 1ns/1ns
`default_nettype none
`include "bltd_map.vh"
module bltd_mode_zero_chk #(parameter LAT_W = 6) (
	input wire logic i_clk, i_rst_n, i_mrs, i_bank_group_bit_zero, i_bank_addr_bit_one, i_bank_addr_bit_zero,
	input wire logic i_rd, i_wr, i_beat_valid, o_interleaved, o_burst_chop_four, o_is_write, o_dq_oe_n,
	input wire logic [2:0] i_beat_idx,
	input wire logic [1:0] o_burst_mode,
	input wire logic [`BLTD_REG_W-1:0] i_addr, o_config,
	input wire logic [LAT_W-1:0] i_column_read_latency, i_added_command_latency,
	input wire logic [LAT_W-1:0] o_write_recovery, o_read_to_precharge_setting, o_total_read_latency
);
	wire acc = i_mrs & ~(i_bank_group_bit_zero | i_bank_addr_bit_one | i_bank_addr_bit_zero);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	cfg_store_a: assert property (acc |-> ##2 o_config == $past(i_addr, 2)) else $error("config not stored");
	cfg_hold_a: assert property ($changed(o_config) |-> $past(acc, 2)) else $error("config changed unasked");
	order_bit_a: assert property (o_interleaved == o_config[3]) else $error("burst order wrong");
	len_code_a: assert property (o_burst_mode == o_config[1:0]) else $error("length wrong");
	rec_decode_a: assert property ($past(i_rst_n) |->
		o_write_recovery == (&o_config[11:10] ? 6'h18 : 6'h0A + 6'h02 * o_config[11:9])
		&& 6'h02 * o_read_to_precharge_setting == o_write_recovery) else $error("recovery decode wrong");
	lat_sum_a: assert property ($past(i_rst_n) |->
		o_total_read_latency == $past(i_added_command_latency + i_column_read_latency)) else $error("latency sum wrong");
	chop_pick_a: assert property ((i_rd || i_wr) |-> ##2 o_burst_chop_four ==
		($past(o_burst_mode, 2) == 2'h2 || $past(o_burst_mode, 2) == 2'h1 && $past(i_addr[12], 2)))
		else $error("chop wrong");
	dq_release_a: assert property (!$past(i_rd || i_wr) |-> o_dq_oe_n ==
		!(i_beat_valid && !o_is_write && !(o_burst_chop_four && i_beat_idx[2]))) else $error("drive enable wrong");
	idle_release_a: assert property (!i_beat_valid |-> o_dq_oe_n) else $error("driven outside slot");
endmodule // bltd_mode_zero_chk
bind bltd_mode_zero bltd_mode_zero_chk #(.LAT_W(LAT_W)) chk_inst (.*);
`default_nettype wire

//--- sim/bltd_ctrl_model.sv
/* Controller model: mode set and read/write commands with beat slots.
 * Assumes one task at a time; results are read by the bench. */
`timescale 1ns/1ns
`default_nettype none
module bltd_ctrl_model (
	input  wire logic        i_clk,
	input  wire logic [2:0]  i_beat_col,
	input  wire logic        i_oe_n,
	output var  logic        o_mrs, o_rd, o_wr, o_bv,
	output var  logic [2:0]  o_sel, o_col, o_bi,
	output var  logic [17:0] o_addr
);
	logic [2:0] cols [8];
	logic       oes [8];
	initial {o_mrs, o_rd, o_wr, o_bv, o_sel, o_col, o_bi, o_addr} = '0;
	task automatic mode_register_set_command(input logic [2:0] sel, input logic [17:0] a);
		@(posedge i_clk);
		o_sel <= sel;
		o_addr <= a & 18'h00E0B;
		o_mrs <= 1'b1;
		@(posedge i_clk);
		o_mrs <= 1'b0;
		// Idle gap before any later command
		@(posedge i_clk);
		@(negedge i_clk);
	endtask
	task automatic cmd(input logic rd, input logic a12, input logic [2:0] col);
		@(posedge i_clk);
		{o_rd, o_wr, o_addr[12], o_col} <= {rd, !rd, a12, col};
		@(posedge i_clk);
		{o_rd, o_wr} <= 2'h0;
		// Column of a slot shows one cycle after it, so nine passes
		for (int i = 0; i < 9; i++) begin
			o_bv <= i < 8;
			o_bi <= 3'(i);
			@(negedge i_clk);
			if (i > 0) cols[i - 1] = i_beat_col;
			if (i < 8) oes[i] = i_oe_n;
			@(posedge i_clk);
		end
		@(negedge i_clk);
	endtask
endmodule // bltd_ctrl_model
`default_nettype wire

//--- sim/tb_top.sv
/* Bench: mode set sweeps, ignored selects, read and write beat orders.
 * Assumes the controller model drives command and address. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic i_clk = 1'b0, i_rst_n = 1'b0, mode_register_set_command, rd, wr, bv, oe_n, chop, isw, il, ch, tm;
	logic [5:0] col_lat = 6'h0B, add_lat = 6'h09, precharge_period = 6'h0C, wrc, read_to_precharge_setting, dal, rl, pull;
	logic [2:0] sel, col, bi, bcol, e;
	logic [1:0] bm;
	logic [17:0] addr, cfg, v;
	int errors = 0, num_checks = 0;
	always #25 i_clk = ~i_clk;
	bltd_ctrl_model bltd_ctrl_model_inst (.i_clk(i_clk), .i_beat_col(bcol), .i_oe_n(oe_n), .o_mrs(mode_register_set_command), .o_rd(rd),
		.o_wr(wr), .o_bv(bv), .o_sel(sel), .o_col(col), .o_bi(bi), .o_addr(addr));
	bltd_mode_zero bltd_mode_zero_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_mrs(mode_register_set_command), .i_bank_group_bit_zero(sel[2]),
		.i_bank_addr_bit_one(sel[1]), .i_bank_addr_bit_zero(sel[0]), .i_addr(addr), .i_column_read_latency(col_lat),
		.i_added_command_latency(add_lat), .i_precharge_period(precharge_period), .i_rd(rd), .i_wr(wr), .i_start_col(col),
		.i_beat_valid(bv), .i_beat_idx(bi), .o_config(cfg), .o_interleaved(il), .o_burst_mode(bm), .o_test_mode(tm),
		.o_write_recovery(wrc), .o_read_to_precharge_setting(read_to_precharge_setting), .o_autoprecharge_write_to_activate(dal),
		.o_total_read_latency(rl), .o_burst_chop_four(chop), .o_is_write(isw), .o_write_pullin(pull),
		.o_beat_col(bcol), .o_dq_oe_n(oe_n));
	task automatic check(input string n, input logic [17:0] seen, input logic [17:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		errors++;
		end_of_test;
	end
	initial begin
		repeat (6) @(posedge i_clk);
		check("cfg reset", cfg, 18'h00000);
		check("oe reset", oe_n, 18'h00001);
		i_rst_n <= 1'b1;
		for (int k = 0; k < 7; k++) begin
			v = 18'(k * 512 + (k % 2) * 8 + k % 3);
			bltd_ctrl_model_inst.mode_register_set_command(3'h0, v);
			check("cfg", cfg, v);
			// Select codes 1..7 in turn, so 111 is among them
			bltd_ctrl_model_inst.mode_register_set_command(3'(k + 1), 18'h00E0A);
			check("cfg kept", cfg, v);
			check("wr", wrc, k == 6 ? 24 : 10 + 2 * k);
			check("rtp", read_to_precharge_setting, k == 6 ? 12 : 5 + k);
			check("dal", dal, (k == 6 ? 24 : 10 + 2 * k) + 12);
			check("rl", rl, 18'h00014);
			check("order", il, k % 2);
			check("test mode", tm, 18'h00000);
			check("len", bm, k % 3);
			ch = k % 3 == 2 || (k % 3 == 1 && k > 3);
			for (int r = 0; r < 2; r++) begin
				bltd_ctrl_model_inst.cmd(r == 0, k > 3, 3'(k));
				check("chop", chop, ch);
				check("pullin", pull, k % 3 == 2 ? 2 : 0);
				for (int i = 0; i < 8; i++) begin
					e = r ? {ch ? k[2] : i[2], i[1:0]} : {k[2] ^ i[2], k % 2 ? k[1:0] ^ i[1:0] : 2'(k[1:0] + i[1:0])};
					if (!ch || i < 4) check("col", bltd_ctrl_model_inst.cols[i], e);
					check("oe", bltd_ctrl_model_inst.oes[i], r == 1 || (ch && i > 3));
				end
			end
		end
		end_of_test;
	end
endmodule // tb_top
`default_nettype wire
